// file: hdl/pcfr_map.vh
// Command codes, field layouts, reset values and codes for the capacitance-detect,
// power-on fault and channel re-map register slice.
// Assumes a command port that presents one decoded command code per access.
//
// Behaviour
// - Write-only arm byte, even bits per channel
// - Arm byte taken as single byte write
// - Measure capacitance only in manual mode
// - Valid resistance result skips capacitance measurement
// - Completion sets done flag, updates results
// - Fault byte readable plain or clear-on-read
// - Two-bit cause per channel, four high
// - Record failed turn-on cause, clear on off
// - Start fault without enable-change flag records cause
// - Allocation refusal reports insufficient power code
// - Re-map byte: four two-bit physical fields
// - Re-map write ignored unless group off
`ifndef PCFR_MAP_VH
`define PCFR_MAP_VH
`define PCFR_CMD_CAP_ARM 8'h22
`define PCFR_CMD_FAULT 8'h24
`define PCFR_CMD_FAULT_CLR 8'h25
`define PCFR_CMD_REMAP 8'h26
`define PCFR_ARM_MASK 8'h55
`define PCFR_RESET_BYTE 8'h00
`define PCFR_REMAP_RESET 8'hE4
`define PCFR_NCH 4
`define PCFR_CH_RESET 4'h0
`define PCFR_CODE_NONE 2'h0
`define PCFR_CODE_BAD_DET 2'h1
`define PCFR_CODE_CLASS_ERR 2'h2
`define PCFR_CODE_NO_POWER 2'h3
`endif

// file: hdl/pcfr_fault_slot.v
// One channel's two-bit power-on fault cause.
// Assumes fault events and turn-off are one-cycle pulses on the system clock.
`timescale 1ns/100ps
`default_nettype none
`include "pcfr_map.vh"
module pcfr_fault_slot (
  // Clock and reset.
  input wire clk_i,
  input wire rst_i,
  // Events.
  input wire fail_i,
  input wire [1:0] cause_i,
  input wire no_power_i,
  input wire off_i,
  input wire clear_i,
  // State.
  output reg [1:0] code_o
);
  // New faults take priority over both the turn-off and read clears.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      code_o <= `PCFR_CODE_NONE;
    end else if (no_power_i) begin
      code_o <= `PCFR_CODE_NO_POWER;
    end else if (fail_i) begin
      code_o <= cause_i;
    end else if (off_i || clear_i) begin
      code_o <= `PCFR_CODE_NONE;
    end
  end
endmodule
`default_nettype wire

// file: hdl/pcfr_cap_slot.v
// One channel's capacitance measurement arm and completion sequencing.
// Assumes the measuring engine reports resistance validity and completion as pulses.
`timescale 1ns/100ps
`default_nettype none
module pcfr_cap_slot (
  // Clock and reset.
  input wire clk_i,
  input wire rst_i,
  // Control.
  input wire arm_i,
  input wire manual_i,
  input wire launch_i,
  input wire res_done_i,
  input wire res_valid_i,
  input wire meas_done_i,
  // Results.
  output reg start_o,
  output reg done_o
);
  reg waiting;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      waiting <= 1'b0;
    end else if (launch_i) begin
      waiting <= arm_i && manual_i;
    end else if (waiting && res_done_i) begin
      waiting <= 1'b0;
    end
  end
  // Start and done are left unregistered here so that the single register in the top
  // answers one edge after the cause; a channel that leaves manual mode never starts.
  always @* begin
    start_o = waiting && !launch_i && res_done_i && !res_valid_i && manual_i;
    done_o = meas_done_i;
  end
endmodule
`default_nettype wire

// file: hdl/pcfr_regs.v
// Register slice: capacitance arm, power-on fault cause and channel re-map.
// Assumes the command interface delivers decoded command codes with one-cycle
// write and read strobes, and that channel engines report events as pulses.
`timescale 1ns/100ps
`default_nettype none
`include "pcfr_map.vh"
module pcfr_regs (
  // Clock and reset.
  input wire SYS_CLK_I,
  input wire SYS_RST_I,
  // Command port.
  input wire [7:0] CMD_I,
  input wire WR_I,
  input wire RD_I,
  input wire [7:0] WDATA_I,
  output reg [7:0] RDATA_O,
  output reg RVALID_O,
  // Channel status.
  input wire [3:0] MANUAL_MODE_I,
  input wire [3:0] CHANNEL_OFF_I,
  input wire [3:0] DETECTION_LAUNCH_I,
  input wire [3:0] RES_DONE_I,
  input wire [3:0] RES_VALID_I,
  input wire [3:0] CAP_MEAS_DONE_I,
  // Power-on events.
  input wire [3:0] CHANNEL_POWER_UP_CMD_I,
  input wire [3:0] START_FAULT_I,
  input wire [7:0] START_FAULT_CAUSE_I,
  input wire [3:0] POWER_ENABLE_CHANGE_FLAG_I,
  input wire [3:0] ALLOC_DENIED_I,
  input wire [3:0] TURN_OFF_I,
  // Measurement and map outputs.
  output reg [3:0] CAP_MEAS_START_O,
  output reg [3:0] DETECTION_DONE_FLAG_O,
  output reg [3:0] RESULT_UPDATE_O,
  output reg [7:0] CHANNEL_MAP_O
);
  reg [7:0] cap_arm;
  reg [7:0] remap;
  reg [3:0] pending_on;
  wire [7:0] fault_byte;
  wire [3:0] start_w;
  wire [3:0] done_w;
  wire clr_read;

  function is_cmd;
    input [7:0] cmd;
    input [7:0] code;
    begin
      is_cmd = (cmd == code);
    end
  endfunction

  assign clr_read = RD_I && is_cmd(CMD_I, `PCFR_CMD_FAULT_CLR);

  genvar ch;
  generate
    for (ch = 0; ch < `PCFR_NCH; ch = ch + 1) begin : g_ch
      pcfr_fault_slot u_fault (
        .clk_i(SYS_CLK_I),
        .rst_i(SYS_RST_I),
        .fail_i((pending_on[ch] || CHANNEL_POWER_UP_CMD_I[ch]) && START_FAULT_I[ch]
                && !POWER_ENABLE_CHANGE_FLAG_I[ch]),
        .cause_i(START_FAULT_CAUSE_I[2*ch+1:2*ch]),
        .no_power_i(ALLOC_DENIED_I[ch] && (pending_on[ch] || CHANNEL_POWER_UP_CMD_I[ch])),
        .off_i(TURN_OFF_I[ch]),
        .clear_i(clr_read),
        .code_o(fault_byte[2*ch+1:2*ch])
      );
      pcfr_cap_slot u_cap (
        .clk_i(SYS_CLK_I),
        .rst_i(SYS_RST_I),
        .arm_i(cap_arm[2*ch]),
        .manual_i(MANUAL_MODE_I[ch]),
        .launch_i(DETECTION_LAUNCH_I[ch]),
        .res_done_i(RES_DONE_I[ch]),
        .res_valid_i(RES_VALID_I[ch]),
        .meas_done_i(CAP_MEAS_DONE_I[ch]),
        .start_o(start_w[ch]),
        .done_o(done_w[ch])
      );
    end
  endgenerate

  always @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      cap_arm <= `PCFR_RESET_BYTE;
      remap <= `PCFR_REMAP_RESET;
      pending_on <= `PCFR_CH_RESET;
      RDATA_O <= `PCFR_RESET_BYTE;
      RVALID_O <= 1'b0;
      CAP_MEAS_START_O <= `PCFR_CH_RESET;
      DETECTION_DONE_FLAG_O <= `PCFR_CH_RESET;
      RESULT_UPDATE_O <= `PCFR_CH_RESET;
      CHANNEL_MAP_O <= `PCFR_REMAP_RESET;
    end else begin
      // A power-up request stays pending until a start fault arrives or the channel turns off.
      pending_on <= (pending_on | CHANNEL_POWER_UP_CMD_I) & ~(START_FAULT_I | TURN_OFF_I);
      if (WR_I && is_cmd(CMD_I, `PCFR_CMD_CAP_ARM)) begin
        cap_arm <= WDATA_I & `PCFR_ARM_MASK;
      end
      if (WR_I && is_cmd(CMD_I, `PCFR_CMD_REMAP) && (&CHANNEL_OFF_I)) begin
        remap <= WDATA_I;
        // The map output moves on the same edge as the stored byte, so the two never disagree.
        CHANNEL_MAP_O <= WDATA_I;
      end
      CAP_MEAS_START_O <= start_w;
      DETECTION_DONE_FLAG_O <= done_w;
      RESULT_UPDATE_O <= done_w;
      RVALID_O <= RD_I;
      if (RD_I) begin
        if (is_cmd(CMD_I, `PCFR_CMD_FAULT) || is_cmd(CMD_I, `PCFR_CMD_FAULT_CLR)) begin
          RDATA_O <= fault_byte;
        end else if (is_cmd(CMD_I, `PCFR_CMD_REMAP)) begin
          RDATA_O <= remap;
        end else begin
          RDATA_O <= `PCFR_RESET_BYTE;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: verif/pcfr_regs_assertions.sv
// Port assertions for the capacitance arm, fault cause and re-map slice.
// Assumes it is bound to pcfr_regs with ports of the same names.
`timescale 1ns/100ps
`default_nettype none
module pcfr_regs_assertions (
  input wire logic SYS_CLK_I, SYS_RST_I, WR_I, RD_I, RVALID_O,
  input wire logic [7:0] CMD_I, WDATA_I, RDATA_O, CHANNEL_MAP_O,
  input wire logic [3:0] MANUAL_MODE_I, CHANNEL_OFF_I, RES_DONE_I, RES_VALID_I, CAP_MEAS_DONE_I,
  input wire logic [3:0] CAP_MEAS_START_O, DETECTION_DONE_FLAG_O, RESULT_UPDATE_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  property p_rv; RD_I |=> RVALID_O; endproperty
  a_rv: assert property (p_rv) else $error("read answer missing");
  property p_norv; !RD_I |=> !RVALID_O; endproperty
  a_norv: assert property (p_norv) else $error("read answer without read");
  property p_arm; RD_I && CMD_I == 8'h22 |=> RDATA_O == 8'h00; endproperty
  a_arm: assert property (p_arm) else $error("arm byte readable");
  property p_mw; WR_I && CMD_I == 8'h26 && &CHANNEL_OFF_I |=> CHANNEL_MAP_O == $past(WDATA_I); endproperty
  a_mw: assert property (p_mw) else $error("map write lost");
  property p_mh; !(WR_I && CMD_I == 8'h26 && &CHANNEL_OFF_I) |=> $stable(CHANNEL_MAP_O); endproperty
  a_mh: assert property (p_mh) else $error("map changed");
  property p_mr; RD_I && CMD_I == 8'h26 |=> RDATA_O == $past(CHANNEL_MAP_O); endproperty
  a_mr: assert property (p_mr) else $error("map read wrong");
  property p_man; (CAP_MEAS_START_O & ~$past(MANUAL_MODE_I)) == 4'h0; endproperty
  a_man: assert property (p_man) else $error("start outside manual");
  property p_skip; (CAP_MEAS_START_O & ~$past(RES_DONE_I & ~RES_VALID_I)) == 4'h0; endproperty
  a_skip: assert property (p_skip) else $error("start without invalid result");
  property p_done; (DETECTION_DONE_FLAG_O & ~$past(CAP_MEAS_DONE_I)) == 4'h0; endproperty
  a_done: assert property (p_done) else $error("done without completion");
  property p_upd; RESULT_UPDATE_O == DETECTION_DONE_FLAG_O; endproperty
  a_upd: assert property (p_upd) else $error("result update apart from done");
  cover property (|CAP_MEAS_START_O);
  cover property (|DETECTION_DONE_FLAG_O);
  cover property (RD_I && CMD_I == 8'h25);
endmodule
bind pcfr_regs pcfr_regs_assertions chk (.*);
`default_nettype wire

// file: verif/pcfr_host.sv
// Host model issuing single-byte command accesses.
// Assumes one-cycle strobes and a read answer one edge later.
`timescale 1ns/100ps
`default_nettype none
module pcfr_host (
  input wire logic clk_i,
  input wire logic rvalid_i,
  input wire logic [7:0] rdata_i,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] cmd_o,
  output logic [7:0] wdata_o
);
  initial begin
    {wr_o, rd_o, cmd_o, wdata_o} = '0;
  end
  // Released command and data lines show the inverse and both strobes drop, so a stale value is never mistaken for a command.
  task xfer(input logic w, input logic [7:0] c, d, output logic [7:0] q, output logic v);
    @(posedge clk_i);
    #1;
    {wr_o, rd_o, cmd_o, wdata_o} = {w, !w, c, d};
    @(posedge clk_i);
    #1;
    {wr_o, rd_o, cmd_o, wdata_o} = {2'b00, ~c, ~d};
    q = rdata_i;
    v = rvalid_i;
  endtask
endmodule
`default_nettype wire

// file: verif/pcfr_regs_test.sv
// Self-checking bench for the register slice.
// Assumes a 100 MHz clock and the host model on the command port.
`timescale 1ns/100ps
`default_nettype none
module pcfr_regs_test;
  logic clk, rst, v;
  logic [3:0] man, off, lnch, rdn, rok, cdn, pup, sf, pec, deny, toff;
  logic [7:0] cause, q, e;
  logic [1:0] code;
  wire wr, rd, rv;
  wire [7:0] cmd, wd, rdat, map;
  wire [3:0] st, dfl, upd;
  int n_fail, n_tests, cyc;
  integer seed = 32'h805d;
  pcfr_host host (.clk_i(clk), .rvalid_i(rv), .rdata_i(rdat), .wr_o(wr), .rd_o(rd), .cmd_o(cmd), .wdata_o(wd));
  pcfr_regs uut (.SYS_CLK_I(clk), .SYS_RST_I(rst), .CMD_I(cmd), .WR_I(wr), .RD_I(rd), .WDATA_I(wd),
    .RDATA_O(rdat), .RVALID_O(rv), .MANUAL_MODE_I(man), .CHANNEL_OFF_I(off), .DETECTION_LAUNCH_I(lnch),
    .RES_DONE_I(rdn), .RES_VALID_I(rok), .CAP_MEAS_DONE_I(cdn), .CHANNEL_POWER_UP_CMD_I(pup),
    .START_FAULT_I(sf), .START_FAULT_CAUSE_I(cause), .POWER_ENABLE_CHANGE_FLAG_I(pec),
    .ALLOC_DENIED_I(deny), .TURN_OFF_I(toff), .CAP_MEAS_START_O(st), .DETECTION_DONE_FLAG_O(dfl),
    .RESULT_UPDATE_O(upd), .CHANNEL_MAP_O(map));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task stop_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      stop_test;
    end
  end
  task chk(input string nm, input logic [7:0] s, x);
    n_tests++;
    if (s !== x) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
    end
  endtask
  task rdc(input logic [7:0] c, x);
    host.xfer(1'b0, c, 8'h00, q, v);
    chk("read valid", {7'h0, v}, 8'h01);
    chk("read data", q, x);
  endtask
  // Expected start mask: manual channels whose resistance result came back invalid.
  function automatic logic [7:0] exp_start(input logic [3:0] m, d, ok);
    return {4'h0, m & d & ~ok};
  endfunction
  task step;
    @(posedge clk);
    #1;
  endtask
  initial begin
    rst = 1;
    {man, lnch, rdn, rok, cdn, pup, sf, pec, deny, toff, cause} = '0;
    off = 4'hF;
    repeat (10) @(posedge clk);
    #1 rst = 0;
    rdc(8'h26, 8'hE4);
    rdc(8'h24, 8'h00);
    rdc(8'h30, 8'h00);
    host.xfer(1'b1, 8'h22, 8'hFF, q, v);
    rdc(8'h22, 8'h00);
    off = 4'h0;
    man = 4'h5;
    step;
    lnch = 4'hF;
    step;
    {lnch, rdn, rok} = {4'h0, 4'hF, 4'h4};
    step;
    rdn = 4'h0;
    cdn = 4'h1;
    chk("start", {4'h0, st}, exp_start(man, 4'hF, 4'h4));
    step;
    cdn = 4'h0;
    chk("done", {4'h0, dfl}, 8'h01);
    chk("update", {4'h0, upd}, 8'h01);
    e = 8'h00;
    for (int ch = 0; ch < 4; ch++) begin
      code = (ch == 3) ? 2'h3 : 2'($random(seed));
      e[2*ch +: 2] = code;
      step;
      pup[ch] = 1'b1;
      step;
      pup = 4'h0;
      if (code == 2'h3) deny[ch] = 1'b1;
      else {sf[ch], cause[2*ch +: 2]} = {1'b1, code};
      step;
      {sf, deny} = '0;
    end
    {pec[1], sf[1], cause[3:2]} = {2'b11, ~e[3:2]};
    step;
    {pec, sf, toff} = {8'h00, 4'h1};
    e[1:0] = 2'h0;
    step;
    toff = 4'h0;
    rdc(8'h24, e);
    rdc(8'h25, e);
    rdc(8'h24, 8'h00);
    e = 8'($random(seed));
    if (e == 8'hE4) e = 8'h1B;
    off = 4'h7;
    host.xfer(1'b1, 8'h26, e, q, v);
    chk("map ignored", map, 8'hE4);
    rdc(8'h26, 8'hE4);
    off = 4'hF;
    host.xfer(1'b1, 8'h26, e, q, v);
    chk("map", map, e);
    rdc(8'h26, e);
    stop_test;
  end
endmodule
`default_nettype wire
